/* hdl/pdt_pkg.sv */
// Package with register map, field positions, reset values and timing for the down timer.
package pdt_pkg;
  localparam logic [7:0] PDT_ADDR_PRESCALER = 8'hd2;
  localparam logic [7:0] PDT_ADDR_COUNT     = 8'hd3;
  localparam logic [7:0] PDT_ADDR_STATUS    = 8'hd4;
  localparam logic [6:0] PDT_PRESC_RELOAD   = 7'h7f;
  localparam logic [7:0] PDT_COUNT_RELOAD   = 8'hff;
  localparam logic [7:0] PDT_STATUS_RESET   = 8'h00;
  localparam int         PDT_BIT_FLAG       = 7;
  localparam int         PDT_BIT_IRQ_EN     = 6;
  localparam int         PDT_BIT_DIR        = 5;
  localparam int         PDT_BIT_DATA       = 4;
  localparam int         PDT_BIT_RUN        = 3;
  localparam int         PDT_TAP_LSB        = 0;
  localparam int         PDT_TAP_W          = 3;
  localparam int         PDT_INT_DIV        = 12;
  localparam logic [3:0] PDT_DIV_LAST       = 4'hb;
  typedef enum logic [1:0] {PDT_EVENT, PDT_GATED, PDT_OUT_LOW, PDT_OUT_HIGH} pdt_mode_t;
endpackage

/* hdl/pdt_timer.sv */
// Prescaled 8-bit down timer with four pin modes and a byte register port.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module pdt_timer
  import pdt_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Register port.
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Low-power state of the core.
  input  wire logic       wait_in,
  input  wire logic       stop_in,
  // Timer pin.
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe_out,
  // Requests.
  output logic            irq_out,
  output logic            wake_out
);
  import pdt_pkg::*;

  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       pin_meta_q;
  logic       pin_sync_q;
  logic       pin_prev_q;
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic [6:0] presc_q;
  logic [6:0] presc_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic       flag_prev_q;
  logic       out_latch_q;
  logic [7:0] rdata_q;

  // Reset is released through two flip-flops so all logic leaves reset together.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Only the second and third stages are read, never the first.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Reset to the idle pull-up level, so leaving reset shows no false rising edge.
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  function automatic logic [6:0] pdt_tap_mask(input logic [2:0] sel);
    pdt_tap_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  wire        w_dir    = status_q[PDT_BIT_DIR];
  wire        w_data   = status_q[PDT_BIT_DATA];
  wire        w_run    = status_q[PDT_BIT_RUN];
  wire        w_flag   = status_q[PDT_BIT_FLAG];
  wire        w_irq_en = status_q[PDT_BIT_IRQ_EN];
  wire [2:0]  w_tap    = status_q[PDT_TAP_LSB +: PDT_TAP_W];
  wire pdt_mode_t w_mode = pdt_mode_t'({w_dir, w_data});
  wire        w_event_mode = (w_mode == PDT_EVENT);
  wire        w_div_tick   = (div_q == PDT_DIV_LAST);
  // Stop freezes the internal clock, so only the external pin may advance the timer.
  wire        w_frozen     = stop_in && !w_event_mode;
  wire        w_pin_rise   = pin_sync_q && !pin_prev_q;
  // Event mode counts pin edges; gated needs the pin high; output mode is free.
  wire        w_presc_tick = !w_run || w_frozen ? 1'b0 :
                             (w_mode == PDT_EVENT) ? w_pin_rise :
                             (w_mode == PDT_GATED) ? (w_div_tick && pin_sync_q) :
                             w_div_tick;
  // The tap fires when the selected low bits of the prescaler are all zero.
  wire        w_count_tick = w_presc_tick &&
                             ((presc_q & pdt_tap_mask(w_tap)) == 7'h00);
  wire        w_wr_presc   = wr_in && (addr_in == PDT_ADDR_PRESCALER);
  wire        w_wr_count   = wr_in && (addr_in == PDT_ADDR_COUNT);
  wire        w_wr_status  = wr_in && (addr_in == PDT_ADDR_STATUS);
  wire        w_underflow  = w_count_tick && (count_q == 8'h01) && !w_wr_count;
  wire        w_flag_set   = w_underflow || (w_wr_count && wdata_in == 8'h00) ||
                             (w_wr_status && wdata_in[PDT_BIT_FLAG]);

  always_comb
  begin
    div_d = w_div_tick || w_frozen ? (w_frozen ? div_q : 4'h0) : div_q + 4'h1;
  end

  always_comb
  begin
    presc_d = presc_q;
    if (!w_run)
      presc_d = PDT_PRESC_RELOAD;
    else if (w_presc_tick)
      presc_d = (presc_q == 7'h00) ? PDT_PRESC_RELOAD : presc_q - 7'h01;
    if (w_wr_presc && w_run)
      presc_d = wdata_in[6:0];
  end

  always_comb
  begin
    count_d = count_q;
    if (w_count_tick && w_run)
      count_d = (count_q == 8'h00) ? PDT_COUNT_RELOAD : count_q - 8'h01;
    if (w_wr_count)
      count_d = wdata_in;
  end

  // The flag is set by underflow, by a zero count write or by writing 1 to it; a write of zero to it clears it,
  // and a simultaneous hardware set still wins.
  always_comb
  begin
    status_d = status_q;
    if (w_wr_status)
      status_d = {w_flag, wdata_in[6:0]};
    if (w_wr_status && !wdata_in[PDT_BIT_FLAG])
      status_d[PDT_BIT_FLAG] = 1'b0;
    if (w_flag_set)
      status_d[PDT_BIT_FLAG] = 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q    <= 4'h0;
      presc_q  <= PDT_PRESC_RELOAD;
      count_q  <= PDT_COUNT_RELOAD;
      status_q <= PDT_STATUS_RESET;
    end
    else
    begin
      div_q    <= div_d;
      presc_q  <= presc_d;
      count_q  <= count_d;
      status_q <= status_d;
    end
  end

  // The data bit is captured only on the flag's rising edge, not continuously.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_prev_q <= 1'b0;
      out_latch_q <= 1'b0;
    end
    else
    begin
      flag_prev_q <= w_flag;
      if (w_flag && !flag_prev_q)
        out_latch_q <= w_data;
    end
  end

  assign pin_out    = out_latch_q;
  assign pin_oe_out = w_dir;
  assign irq_out    = w_flag && w_irq_en;
  assign wake_out   = irq_out;

  wire [7:0] w_rd_mux = (addr_in == PDT_ADDR_PRESCALER) ? {1'b0, presc_q} :
                        (addr_in == PDT_ADDR_COUNT)     ? count_q :
                        (addr_in == PDT_ADDR_STATUS)    ? status_q : 8'h00;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_in ? w_rd_mux : 8'h00;
  end
  assign rdata_out = rdata_q;

  a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n)
    irq_out == (status_q[PDT_BIT_FLAG] && status_q[PDT_BIT_IRQ_EN]))
    else $error("irq level mismatch");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n)
    $fell(w_flag) |-> $past(w_wr_status) && !$past(wdata_in[PDT_BIT_FLAG]))
    else $error("flag cleared without write");
  a_underflow_sets: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_underflow |=> w_flag && count_q == 8'h00)
    else $error("underflow lost");
  a_write_wins: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_wr_count |=> count_q == $past(wdata_in))
    else $error("count write lost");
  a_run_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
    !w_run && !w_wr_count |=> presc_q == PDT_PRESC_RELOAD && $stable(count_q))
    else $error("stopped timer moved");
  a_presc_msb: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(rd_in) && $past(addr_in) == PDT_ADDR_PRESCALER |-> !rdata_out[7])
    else $error("prescaler bit 7 set");
  a_stop_freeze: assert property (@(posedge clk_in) disable iff (!rst_n)
    stop_in && !w_event_mode && !wr_in |=> $stable(count_q) && $stable(presc_q))
    else $error("timer ran in stop");
  a_pin_follow: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_flag && !flag_prev_q |=> pin_out == $past(w_data))
    else $error("pin latch wrong");
  a_zero_write: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_wr_count && wdata_in == 8'h00 |=> w_flag)
    else $error("zero write no flag");

  // Steps of an underflow: the last tick, then the flag rise, then the latched pin.
  sequence s_last_tick;
    w_count_tick && (count_q == 8'h01) && !w_wr_count;
  endsequence

  sequence s_flag_up;
    w_flag && !flag_prev_q;
  endsequence

  sequence s_count_write;
    w_wr_count && (wdata_in != 8'h00);
  endsequence

  a_underflow_pin: assert property (@(posedge clk_in) disable iff (!rst_n)
    s_last_tick ##0 (!w_flag && !w_wr_status) |=> s_flag_up ##1 (pin_out == $past(w_data)))
    else $error("underflow did not reach pin latch");

  a_write_no_flag: assert property (@(posedge clk_in) disable iff (!rst_n)
    s_count_write ##0 (w_count_tick && count_q == 8'h01 && !w_flag && !w_wr_status)
    |=> !w_flag)
    else $error("flag set despite count write");

  a_count_read: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(rd_in) && $past(addr_in) == PDT_ADDR_COUNT |-> rdata_out == $past(count_q))
    else $error("count read wrong");

  a_status_read: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(rd_in) && $past(addr_in) == PDT_ADDR_STATUS |-> rdata_out == $past(status_q))
    else $error("status read wrong");

  a_presc_read: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(rd_in) && $past(addr_in) == PDT_ADDR_PRESCALER |->
    rdata_out == {1'b0, $past(presc_q)})
    else $error("prescaler read wrong");

  a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
    !$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read cycle");

  a_oe_after_write: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_wr_status |=> pin_oe_out == $past(wdata_in[PDT_BIT_DIR]))
    else $error("pin direction not taken");

  a_mode_out: assert property (@(posedge clk_in) disable iff (!rst_n)
    (w_mode == PDT_OUT_HIGH || w_mode == PDT_OUT_LOW) |-> pin_oe_out)
    else $error("output mode without drive");

  a_wake_follow: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_flag && w_irq_en |-> wake_out)
    else $error("no wake request");

  a_irq_drop: assert property (@(posedge clk_in) disable iff (!rst_n)
    !w_flag || !w_irq_en |-> !irq_out && !wake_out)
    else $error("request without flag and enable");

  a_presc_reload: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_presc_tick && presc_q == 7'h00 && !w_wr_presc |=> presc_q == PDT_PRESC_RELOAD)
    else $error("prescaler did not reload");

  a_presc_dec: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_presc_tick && presc_q != 7'h00 && !w_wr_presc |=> presc_q == $past(presc_q) - 7'h01)
    else $error("prescaler did not decrement");

  a_count_reload: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_count_tick && count_q == 8'h00 && !w_wr_count |=> count_q == PDT_COUNT_RELOAD)
    else $error("count did not reload");

  a_count_dec: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_count_tick && count_q != 8'h00 && !w_wr_count |=> count_q == $past(count_q) - 8'h01)
    else $error("count did not decrement");

  a_count_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
    !w_count_tick && !w_wr_count |=> $stable(count_q))
    else $error("count moved without tick");

  a_presc_write: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_wr_presc && w_run |=> presc_q == $past(wdata_in[6:0]))
    else $error("prescaler write lost");

  a_presc_refused: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_wr_presc && !w_run |=> presc_q == PDT_PRESC_RELOAD)
    else $error("prescaler write taken while held");

  a_gated_low: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_run && w_mode == PDT_GATED && !pin_sync_q && !w_wr_count && !w_wr_presc
    |=> $stable(presc_q) && $stable(count_q))
    else $error("gated timer ran with pin low");

  a_event_tick: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_run && w_event_mode && !w_pin_rise && !w_wr_presc |=> $stable(presc_q))
    else $error("event prescaler moved without edge");

  a_output_rate: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_run && w_dir && !w_div_tick && !w_wr_presc |=> $stable(presc_q))
    else $error("output prescaler off divider");

  a_wait_runs: assert property (@(posedge clk_in) disable iff (!rst_n)
    wait_in && !stop_in && w_run && w_mode == PDT_GATED && pin_sync_q && w_div_tick &&
    !w_wr_presc |=> presc_q != $past(presc_q))
    else $error("timer stalled in wait");

  a_div_wrap: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_div_tick && !w_frozen |=> div_q == 4'h0)
    else $error("divider did not wrap");

  a_div_limit: assert property (@(posedge clk_in) disable iff (!rst_n)
    div_q <= PDT_DIV_LAST)
    else $error("divider out of range");

  a_flag_write: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_wr_status && wdata_in[PDT_BIT_FLAG] |=> w_flag)
    else $error("status write did not set flag");

  a_flag_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
    w_flag && !w_wr_status |=> w_flag)
    else $error("flag cleared by hardware");
endmodule

/* tb/pdt_pin_partner.sv */
// Far-side model of the timer pin: a pulled-up line with an event source.
`timescale 1ns/1ps
module pdt_pin_partner (
  input  wire logic clk_in,
  input  wire logic oe_in,
  input  wire logic drive_in,
  output logic      level_out
);
  logic src_q = 1'b1;
  // An undriven pin rests at the pull-up level.
  assign level_out = oe_in ? drive_in : src_q;
  task automatic hold(input logic lvl);
    src_q <= lvl;
  endtask
  // Pulses stay three cycles per phase so the pin synchroniser sees each one.
  task automatic pulses(input int n);
    repeat (n)
    begin
      src_q <= 1'b0;
      repeat (3) @(posedge clk_in);
      src_q <= 1'b1;
      repeat (3) @(posedge clk_in);
    end
  endtask
endmodule

/* tb/pdt_timer_bench.sv */
// Self-checking bench for the prescaled down timer.
`timescale 1ns/1ps
module pdt_timer_bench;
  import pdt_pkg::*;
  logic        clk_in, pin_out, pin_oe_out, irq_out, wake_out, pin_lvl;
  logic        rst_n_in = 1'b0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        rd_seen_q = 1'b0;
  logic        wait_in = 1'b0;
  logic        stop_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic [7:0]  rdata_out;
  logic [7:0]  exp_q[$];
  logic [7:0]  adr_q[$];
  logic [31:0] seed = 32'hfb78deea;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  pdt_timer i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .wait_in(wait_in), .stop_in(stop_in), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .irq_out(irq_out), .wake_out(wake_out));
  pdt_pin_partner i_far (.clk_in(clk_in), .oe_in(pin_oe_out), .drive_in(pin_out),
    .level_out(pin_lvl));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A gap cycle after each strobe keeps every signal to one assignment per step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < lim)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    rd_seen_q <= rd_in;
    cycles <= cycles + 1;
    if (rd_seen_q === 1'b1)
      check($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), rdata_out);
    if (cycles > 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(PDT_ADDR_PRESCALER, 8'h7f);
    rd(PDT_ADDR_COUNT, 8'hff);
    rd(PDT_ADDR_STATUS, 8'h00);
    rd(8'hd5, 8'h00);
    wr(PDT_ADDR_PRESCALER, 8'h05);
    rd(PDT_ADDR_PRESCALER, 8'h7f);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      wr(PDT_ADDR_COUNT, seed[7:0] | 8'h01);
      rd(PDT_ADDR_COUNT, seed[7:0] | 8'h01);
    end
    $display("test registers done");
    wr(PDT_ADDR_STATUS, 8'h40);
    wr(PDT_ADDR_COUNT, 8'h00);
    check("irq", 8'h01, {7'h0, irq_out});
    check("wake", 8'h01, {7'h0, wake_out});
    wr(PDT_ADDR_STATUS, 8'h40);
    check("irq", 8'h00, {7'h0, irq_out});
    wr(PDT_ADDR_STATUS, 8'hc0);
    rd(PDT_ADDR_STATUS, 8'hc0);
    wr(PDT_ADDR_STATUS, 8'h80);
    check("irq", 8'h00, {7'h0, irq_out});
    wr(PDT_ADDR_STATUS, 8'h08);
    wr(PDT_ADDR_PRESCALER, 8'h85);
    rd(PDT_ADDR_PRESCALER, 8'h05);
    $display("test flag and prescaler done");
    for (int t = 0; t < 4; t++)
    begin
      wr(PDT_ADDR_STATUS, 8'h00);
      wr(PDT_ADDR_COUNT, 8'h02);
      wr(PDT_ADDR_STATUS, 8'h08 | 8'(t));
      i_far.pulses(2 << t);
      repeat (6) @(posedge clk_in);
      rd(PDT_ADDR_STATUS, 8'h88 | 8'(t));
      rd(PDT_ADDR_COUNT, 8'h00);
    end
    i_far.pulses(8);
    repeat (6) @(posedge clk_in);
    rd(PDT_ADDR_COUNT, 8'hff);
    $display("test event taps done");
    wr(PDT_ADDR_STATUS, 8'h00);
    wr(PDT_ADDR_COUNT, 8'h02);
    wr(PDT_ADDR_STATUS, 8'h78);
    check("oe", 8'h01, {7'h0, pin_oe_out});
    check("pin", 8'h00, {7'h0, pin_out});
    wait_irq(60);
    repeat (2) @(posedge clk_in);
    check("irq", 8'h01, {7'h0, irq_out});
    check("pin", 8'h01, {7'h0, pin_out});
    stop_in <= 1'b1;
    wr(PDT_ADDR_COUNT, 8'h05);
    repeat (60) @(posedge clk_in);
    rd(PDT_ADDR_COUNT, 8'h05);
    $display("test output and stop done");
    stop_in <= 1'b0;
    wait_in <= 1'b1;
    i_far.hold(1'b0);
    wr(PDT_ADDR_STATUS, 8'h00);
    wr(PDT_ADDR_COUNT, 8'h02);
    wr(PDT_ADDR_STATUS, 8'h58);
    repeat (60) @(posedge clk_in);
    rd(PDT_ADDR_COUNT, 8'h02);
    i_far.hold(1'b1);
    wait_irq(60);
    check("irq", 8'h01, {7'h0, irq_out});
    $display("test gated done");
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("oe", 8'h00, {7'h0, pin_oe_out});
    rd(PDT_ADDR_COUNT, 8'hff);
    rd(PDT_ADDR_STATUS, 8'h00);
    repeat (2) @(posedge clk_in);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
